// *** pkg/cas_pkg.sv ***
/*
 Constants for the cell front-end control and status block: control frame layout,
 status word layout, frame length and reset values.
 Assumes a 24-bit serial frame, most significant bit first.
*/
package cas_pkg;
   // ------------------------------------------------------------------
   // frame
   // ------------------------------------------------------------------
   localparam int          FRAME_BITS    = 24;
   localparam int          CELLS         = 16;
   localparam logic [4:0]  FRAME_COUNT   = 5'h18;
   localparam logic [23:0] CTRL_RESET    = 24'h000000;
   localparam logic [23:0] STATUS_RESET  = 24'h000000;
   localparam int          SYNC_STAGES   = 2;

   // ------------------------------------------------------------------
   // control word fields
   // ------------------------------------------------------------------
   localparam int BAL_LSB       = 0;
   localparam int CELL_SEL_BIT  = 16;
   localparam int SEL_LSB       = 17;
   localparam int HOLD_REQ_BIT  = 21;
   localparam int OPEN_WIRE_BIT = 22;
   localparam int STANDBY_BIT   = 23;

   // ------------------------------------------------------------------
   // monitor_status_word fields
   // ------------------------------------------------------------------
   localparam int ST_CELL_LSB   = 0;
   localparam int ST_PART_LSB   = 16;
   localparam int ST_DIE_LSB    = 18;
   localparam int ST_ASUP_BIT   = 20;
   localparam int ST_SSUP_BIT   = 21;
   localparam int ST_NRDY_BIT   = 22;
   localparam int ST_OTEMP_BIT  = 23;

   // arbitrary identity values, not taken from any part
   localparam logic [1:0] PART_CODE   = 2'h3;
   localparam logic [1:0] DIE_VERSION = 2'h1;

   // aux codes on select bits 1:0
   localparam logic [1:0] AUX_NONE = 2'h0;

   typedef enum logic [1:0] {
      CAS_ROUTE_OFF,
      CAS_ROUTE_CELL,
      CAS_ROUTE_AUX_BUF,
      CAS_ROUTE_AUX_DIRECT
   } cas_route_t;
endpackage : cas_pkg

// *** rtl/cas_sync.sv ***
/*
 Two-stage synchroniser for a bus of independent level signals.
 Assumes each bit is a slow level; multi-bit values are not coherent across bits.
*/
`timescale 1ns/10ps
module cas_sync
   import cas_pkg::*;
#(
   parameter int WIDTH = 1
) (
   input  wire logic             clk_sys,
   input  wire logic             rstn,
   input  wire logic [WIDTH-1:0] asyncIn,
   output logic      [WIDTH-1:0] syncOut
);
   logic [WIDTH-1:0] meta;

   // first stage feeds only the second stage
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         meta    <= '0;
         syncOut <= '0;
      end else begin
         meta    <= asyncIn;
         syncOut <= meta;
      end
   end
endmodule : cas_sync

// *** rtl/cas_ctrl.sv ***
/*
 Control and status logic of a multi-cell measurement front end: serial slave that
 takes a 24-bit control word, drives routing, phase, diagnostic, power and balancing
 controls, and returns a 24-bit monitor status word.
 Assumes serial pins and analog comparator levels are asynchronous to clk_sys; the
 serial clock is far slower than clk_sys (at least four clk_sys per half period).
*/
`timescale 1ns/10ps
// How it works
// - cell readout decodes four select bits binary, code k routes cell k+1
// - aux select: pattern 1,0 first, 0,1 second, 1,1 third input
// - readout 0, select bits 2 and 3 high: aux through buffer to output
// - readout 0, bit 2 low, bit 3 high: aux connected directly, no buffer
// - aux modes with bits 0,1 both low three-state the analog output
// - status bits 0 to 15 flag cell below threshold or above supply in hold
// - status word shifted out: cell flags low, part code 16, die version 18
// - status bit 20 reports analog supply undervoltage
// - status bit 21 reports stack supply low, forced 1 in standby
// - status bit 22 reports not ready during power-up or self-calibration
// - status bit 23 reports thermal shutdown
// - thermal shutdown stops regulator, amplifier, balancing; serial port keeps working
// - standby disables the amplifier, regulator stays on
// - each balance gate follows its written enable bit, off when clear
// - cell routing takes effect after the rising chip-select edge ending the write
// - hold request 0 follows track pin for sampling; 1 forces hold
// - open-wire test enable sinks leakage on every cell tap
// - control bit 23 selects standby low-power mode
module cas_ctrl
   import cas_pkg::*;
(
   input  wire logic              clk_sys,
   input  wire logic              rstn,
   input  wire logic              sclkPin,
   input  wire logic              csPin_n,
   input  wire logic              sdiPin,
   input  wire logic              trackControlPin,
   input  wire logic [CELLS-1:0]  cellLowCmp,
   input  wire logic              analogSupplyLowCmp,
   input  wire logic              stackSupplyLowCmp,
   input  wire logic              powerUpBusy,
   input  wire logic              calibrationBusy,
   input  wire logic              overtempCmp,
   output logic                   sdoPin,
   output logic [CELLS-1:0]       balanceGate,
   output logic [3:0]             cellMuxSel,
   output logic                   cellMuxEn,
   output logic [1:0]             auxMuxSel,
   output logic                   auxBufferEn,
   output logic                   auxDirectEn,
   output logic                   analogOutputEn,
   output logic                   holdPhase,
   output logic                   openWireSinkEn,
   output logic                   amplifierEn,
   output logic                   regulatorEn,
   output logic                   standbyMode
);
   // ------------------------------------------------------------------
   // input synchronisers
   // ------------------------------------------------------------------
   localparam int NSYNC = CELLS + 9;

   logic [NSYNC-1:0] syncBus;
   logic             sclkS;
   logic             csS_n;
   logic             csSelS;
   logic             sdiS;
   logic             trackS;
   logic [CELLS-1:0] cellLowS;
   logic             aSupLowS;
   logic             sSupLowS;
   logic             notReadyS;
   logic             overtempS;

   cas_sync #(
      .WIDTH   (NSYNC)
   ) u_sync (
      .clk_sys (clk_sys),
      .rstn    (rstn),
      // select enters inverted so the synchroniser reset level reads as deselected,
      // otherwise a false frame start would follow every reset
      .asyncIn ({sclkPin, ~csPin_n, sdiPin, trackControlPin, cellLowCmp,
                 analogSupplyLowCmp, stackSupplyLowCmp, powerUpBusy,
                 calibrationBusy, overtempCmp}),
      .syncOut (syncBus)
   );

   assign {sclkS, csSelS, sdiS, trackS, cellLowS, aSupLowS, sSupLowS} = syncBus[NSYNC-1:3];
   assign csS_n     = !csSelS;
   assign notReadyS = syncBus[2] | syncBus[1];
   assign overtempS = syncBus[0];

   // ------------------------------------------------------------------
   // edge detection on synchronised serial pins
   // ------------------------------------------------------------------
   logic sclkD;
   logic csD_n;

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         sclkD <= 1'b0;
         csD_n <= 1'b1;
      end else begin
         sclkD <= sclkS;
         csD_n <= csS_n;
      end
   end

   logic frameOn;
   logic frameStart;
   logic frameEnd;
   logic sclkRise;
   logic sclkFall;

   assign frameOn    = !csS_n;
   assign frameStart = csD_n && !csS_n;
   assign frameEnd   = !csD_n && csS_n;
   assign sclkRise   = frameOn && !sclkD && sclkS;
   assign sclkFall   = frameOn && sclkD && !sclkS;

   // ------------------------------------------------------------------
   // control word and live status
   // ------------------------------------------------------------------
   logic [23:0] ctrl;
   logic [23:0] statusNow;
   logic        holdNow;
   logic        standbyNow;

   assign standbyNow = ctrl[STANDBY_BIT];
   assign holdNow    = ctrl[HOLD_REQ_BIT] || !trackS;

   always_comb begin
      statusNow = STATUS_RESET;
      statusNow[ST_CELL_LSB +: CELLS] = holdNow ? cellLowS : '0;
      statusNow[ST_PART_LSB +: 2]     = PART_CODE;
      statusNow[ST_DIE_LSB +: 2]      = DIE_VERSION;
      statusNow[ST_ASUP_BIT]          = aSupLowS;
      statusNow[ST_SSUP_BIT]          = sSupLowS || standbyNow;
      statusNow[ST_NRDY_BIT]          = notReadyS;
      statusNow[ST_OTEMP_BIT]         = overtempS;
   end

   // ------------------------------------------------------------------
   // serial shifter: status out msb first, control in; daisy-chain capable
   // ------------------------------------------------------------------
   logic [23:0] shifter;
   logic [4:0]  bitCount;

   // status snapshot at frame start keeps the word coherent while it shifts
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         shifter <= STATUS_RESET;
      end else if (frameStart) begin
         shifter <= statusNow;
      end else if (sclkRise) begin
         shifter <= {shifter[22:0], sdiS};
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         sdoPin <= 1'b0;
      end else if (frameStart) begin
         sdoPin <= statusNow[FRAME_BITS-1];
      end else if (sclkFall) begin
         sdoPin <= shifter[FRAME_BITS-1];
      end
   end

   // counter saturates: a longer chain frame keeps the last 24 bits
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         bitCount <= 5'h00;
      end else if (frameStart) begin
         bitCount <= 5'h00;
      end else if (sclkRise && bitCount != FRAME_COUNT) begin
         bitCount <= bitCount + 5'h01;
      end
   end

   // short frames are dropped so a glitch on chip select cannot corrupt control
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         ctrl <= CTRL_RESET;
      end else if (frameEnd && bitCount == FRAME_COUNT) begin
         ctrl <= shifter;
      end
   end

   // ------------------------------------------------------------------
   // routing decode
   // ------------------------------------------------------------------
   function automatic cas_route_t routeOf(input logic cellSel, input logic [3:0] sel);
      cas_route_t r;
      r = CAS_ROUTE_OFF;
      if (cellSel) begin
         r = CAS_ROUTE_CELL;
      end else if (sel[3] && sel[1:0] != AUX_NONE) begin
         r = sel[2] ? CAS_ROUTE_AUX_BUF : CAS_ROUTE_AUX_DIRECT;
      end
      return r;
   endfunction : routeOf

   cas_route_t route;
   logic [3:0] selBits;

   assign selBits = ctrl[SEL_LSB +: 4];
   assign route   = routeOf(ctrl[CELL_SEL_BIT], selBits);

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         cellMuxSel     <= 4'h0;
         cellMuxEn      <= 1'b0;
         auxMuxSel      <= 2'h0;
         auxBufferEn    <= 1'b0;
         auxDirectEn    <= 1'b0;
         analogOutputEn <= 1'b0;
      end else begin
         cellMuxSel     <= selBits;
         cellMuxEn      <= route == CAS_ROUTE_CELL;
         // aux select: bit 0 weighs 1, bit 1 weighs 2, so 1 first, 2 second, 3 third
         auxMuxSel      <= selBits[1:0];
         auxBufferEn    <= route == CAS_ROUTE_AUX_BUF;
         auxDirectEn    <= route == CAS_ROUTE_AUX_DIRECT;
         analogOutputEn <= route != CAS_ROUTE_OFF;
      end
   end

   // ------------------------------------------------------------------
   // phase, diagnostics, power and balancing
   // ------------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         holdPhase      <= 1'b0;
         openWireSinkEn <= 1'b0;
         standbyMode    <= 1'b0;
      end else begin
         holdPhase      <= holdNow;
         openWireSinkEn <= ctrl[OPEN_WIRE_BIT];
         standbyMode    <= standbyNow;
      end
   end

   // regulator is off in reset and turns on at the first clock after it, before the synchronisers settle
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         amplifierEn <= 1'b0;
         regulatorEn <= 1'b0;
         balanceGate <= '0;
      end else begin
         amplifierEn <= !overtempS && !standbyNow;
         regulatorEn <= !overtempS;
         balanceGate <= overtempS ? '0 : ctrl[BAL_LSB +: CELLS];
      end
   end
endmodule : cas_ctrl

// *** tb/cas_ctrl_monitor.sv ***
/*
 Port-level assertions for cas_ctrl, bound to every instance.
 Assumes the serial pins change on clk_sys edges and are far slower than clk_sys.
*/
`timescale 1ns/10ps
module cas_ctrl_monitor
   import cas_pkg::*;
(
   input wire logic             clk_sys,
   input wire logic             rstn,
   input wire logic             sclkPin,
   input wire logic             csPin_n,
   input wire logic             trackControlPin,
   input wire logic             overtempCmp,
   input wire logic             sdoPin,
   input wire logic [CELLS-1:0] balanceGate,
   input wire logic [3:0]       cellMuxSel,
   input wire logic             cellMuxEn,
   input wire logic [1:0]       auxMuxSel,
   input wire logic             auxBufferEn,
   input wire logic             auxDirectEn,
   input wire logic             analogOutputEn,
   input wire logic             holdPhase,
   input wire logic             amplifierEn,
   input wire logic             regulatorEn,
   input wire logic             standbyMode
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   // ------------------------------------------------------------------
   // routing, power and serial timing
   // ------------------------------------------------------------------
   chk_cell_drives: assert property (cellMuxEn |-> analogOutputEn)
      else $error("cell routed but output three-stated");
   chk_out_cause: assert property (analogOutputEn |-> cellMuxEn || auxBufferEn || auxDirectEn)
      else $error("output driven with no source");
   chk_aux_none: assert property (
      !cellMuxEn && auxMuxSel == AUX_NONE |-> !analogOutputEn)
      else $error("no cell and aux none but output driven");
   chk_aux_excl: assert property (!(auxBufferEn && auxDirectEn))
      else $error("buffered and direct aux together");
   chk_standby_amp: assert property (standbyMode |-> !amplifierEn)
      else $error("amplifier on in standby");
   chk_ot_stop: assert property (
      overtempCmp [*6] |-> !amplifierEn && !regulatorEn && balanceGate == '0)
      else $error("overtemp left circuits running");
   chk_reg_on: assert property (!overtempCmp [*6] |-> regulatorEn)
      else $error("regulator off without overtemp");
   chk_hold_track: assert property ($fell(trackControlPin) |-> ##[1:5] holdPhase)
      else $error("track low did not give hold");
   chk_sel_stable: assert property ($fell(csPin_n) |=> $stable(cellMuxSel) [*8])
      else $error("cell select moved inside a frame");
   chk_sdo_steady: assert property ($rose(sclkPin) |-> $stable(sdoPin) [*8])
      else $error("serial output moved while clock high");
   cov_cell: cover property (cellMuxEn);
   cov_buf: cover property (auxBufferEn && analogOutputEn);
   cov_dir: cover property (auxDirectEn && analogOutputEn);
   cov_ot: cover property (overtempCmp && !regulatorEn);
endmodule : cas_ctrl_monitor

bind cas_ctrl cas_ctrl_monitor u_mon (.clk_sys, .rstn, .sclkPin, .csPin_n, .trackControlPin,
   .overtempCmp, .sdoPin, .balanceGate, .cellMuxSel, .cellMuxEn, .auxMuxSel, .auxBufferEn,
   .auxDirectEn, .analogOutputEn, .holdPhase, .amplifierEn, .regulatorEn, .standbyMode);

// *** tb/cas_host_model.sv ***
/*
 Host serial master: mode 0, msb first, clock idle low outside frames.
 Assumes clk_sys at 200 MHz; every pin moves just after a clk_sys edge.
*/
`timescale 1ns/10ps
module cas_host_model (
   input  wire logic clk_sys,
   input  wire logic sdoPin,
   output logic      sclkPin,
   output logic      csPin_n,
   output logic      sdiPin
);
   initial begin
      sclkPin = 1'b0;
      csPin_n = 1'b1;
      sdiPin  = 1'b0;
   end
   // 12 plus 13 system cycles make the 125 ns link period
   task automatic frame(input logic [23:0] w, input int nb, output logic [23:0] rd);
      rd = '0;
      csPin_n <= 1'b0;
      repeat (13) @(posedge clk_sys);
      for (int i = nb - 1; i >= 0; i--) begin
         sdiPin <= w[i];
         repeat (12) @(posedge clk_sys);
         sclkPin <= 1'b1;
         rd[i] = sdoPin;
         repeat (13) @(posedge clk_sys);
         sclkPin <= 1'b0;
      end
      repeat (12) @(posedge clk_sys);
      csPin_n <= 1'b1;
      // released data line must not look like the last bit
      sdiPin <= ~sdiPin;
      repeat (12) @(posedge clk_sys);
   endtask : frame
endmodule : cas_host_model

// *** tb/tb.sv ***
/*
 Self-checking bench for cas_ctrl: frames from the host model, random levels.
 Assumes the host model owns the serial pins and the bound checker.
*/
`timescale 1ns/10ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin err_count++; \
   $display("BAD %0t got %h exp %h", $time, g, e); end end
module tb;
   import cas_pkg::*;
   logic        clk_sys = 0, rstn = 0, trackControlPin = 0, overtempCmp = 0;
   logic        analogSupplyLowCmp = 0, stackSupplyLowCmp = 0;
   logic        powerUpBusy = 0, calibrationBusy = 0;
   logic [15:0] cellLowCmp = 0, balanceGate;
   logic        sclkPin, csPin_n, sdiPin, sdoPin, cellMuxEn, auxBufferEn, auxDirectEn;
   logic        analogOutputEn, holdPhase, openWireSinkEn, amplifierEn, regulatorEn;
   logic        standbyMode;
   logic [3:0]  cellMuxSel;
   logic [1:0]  auxMuxSel;
   logic [31:0] seed = 32'h44d448ea, v;
   logic [23:0] w, cur, rd, st;
   logic [17:0] owx;
   int          err_count = 0, tests_run = 0, cyc = 0, nb;

   initial forever #2.5 clk_sys = ~clk_sys;

   cas_ctrl u_dut (.clk_sys, .rstn, .sclkPin, .csPin_n, .sdiPin, .trackControlPin, .cellLowCmp,
      .analogSupplyLowCmp, .stackSupplyLowCmp, .powerUpBusy, .calibrationBusy, .overtempCmp,
      .sdoPin, .balanceGate, .cellMuxSel, .cellMuxEn, .auxMuxSel, .auxBufferEn, .auxDirectEn,
      .analogOutputEn, .holdPhase, .openWireSinkEn, .amplifierEn, .regulatorEn, .standbyMode);
   cas_host_model u_host (.clk_sys, .sdoPin, .sclkPin, .csPin_n, .sdiPin);

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd

   // status snapshot seen at frame start, under the word applied before it
   function automatic logic [23:0] exp_st(logic [23:0] c, logic h);
      return {overtempCmp, powerUpBusy | calibrationBusy, stackSupplyLowCmp | c[STANDBY_BIT],
              analogSupplyLowCmp, DIE_VERSION, PART_CODE, h ? cellLowCmp : 16'h0000};
   endfunction : exp_st

   task automatic check_out();
      logic [3:0] s;
      logic       on;
      logic       aux;
      s = cur[20:17];
      aux = ~cur[CELL_SEL_BIT] & s[3] & (s[1:0] != AUX_NONE);
      on = cur[CELL_SEL_BIT] | aux;
      `CHK(cellMuxEn, cur[CELL_SEL_BIT])
      if (cur[CELL_SEL_BIT]) `CHK(cellMuxSel, s)
      `CHK(analogOutputEn, on)
      `CHK({auxBufferEn, auxDirectEn}, aux ? {s[2], ~s[2]} : 2'b00)
      if (aux) `CHK(auxMuxSel, s[1:0])
      `CHK(balanceGate, overtempCmp ? 16'h0000 : cur[15:0])
      `CHK(holdPhase, cur[HOLD_REQ_BIT] | ~trackControlPin)
      `CHK(openWireSinkEn, cur[OPEN_WIRE_BIT])
      `CHK(standbyMode, cur[STANDBY_BIT])
      `CHK({amplifierEn, regulatorEn}, {~overtempCmp & ~cur[STANDBY_BIT], ~overtempCmp})
   endtask : check_out

   task automatic give_verdict();
      $display("errors %0d checks %0d", err_count, tests_run);
      if (err_count == 0 && tests_run > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : give_verdict

   // ------------------------------------------------------------------
   // all cell codes, all aux codes, random words with one short frame, then open-wire pairs
   // ------------------------------------------------------------------
   initial begin
      cur = CTRL_RESET;
      repeat (3) @(posedge clk_sys);
      rstn <= 1'b1;
      for (int i = 0; i < 40; i++) begin
         v = rnd();
         w = v[23:0];
         if (i < 16) w[20:16] = {i[3:0], 1'b1};
         else if (i < 24) w[20:16] = {1'b1, i[2:0], 1'b0};
         // open-wire pairs: leak plus one balanced cell while sampling, then hold and route it;
         // the settle wait before hold is cut to bench scale, far below the real figure
         else if (i >= 32) begin
            if (i[0]) w = {3'h1, 1'b0, i[3:1], 1'b1, 16'h0000};
            else w = {3'h2, 5'h00, 16'h0001 << i[3:1]};
         end
         nb = (i == 30) ? 20 : 24;
         @(posedge clk_sys);
         v = rnd();
         // open-wire pairs keep the track pin high so the first frame really samples
         {trackControlPin, analogSupplyLowCmp, stackSupplyLowCmp} <= v[2:0] | {i >= 32, 2'b00};
         {powerUpBusy, calibrationBusy} <= v[4:3];
         overtempCmp <= (v[7:5] == 3'h0) && (i < 32);
         cellLowCmp <= v[31:16];
         repeat (8) @(posedge clk_sys);
         st = exp_st(cur, cur[HOLD_REQ_BIT] | ~trackControlPin);
         u_host.frame(w, nb, rd);
         // a short frame must leave the applied word alone
         if (nb == 24) begin
            `CHK(rd, st)
            cur = w;
         end else begin
            `CHK(rd[19:0], st[23:4])
         end
         repeat (6) @(posedge clk_sys);
         #1;
         check_out();
         if (i >= 32) begin
            owx = i[0] ? {1'b0, 16'h0000, 1'b1} : {1'b1, 16'h0001 << i[3:1], 1'b0};
            `CHK({openWireSinkEn, balanceGate, holdPhase}, owx)
         end
      end
      give_verdict();
   end

   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 40000) begin
         err_count++;
         give_verdict();
      end
   end
endmodule : tb
